// >>> logic/counter_array_pkg.sv
// Summary of operation
// - all 8-11 bit pwm modules share cycle length
// - 8-bit: low byte match drives output high
// - 8-bit: low byte overflow drives output low
// - 8-bit: wrap copies compare high into low
// - 8-bit match sets event flag when enabled
// - 8-bit cycle overflow flag every 256 ticks
// - low write clears, high write sets enable
// - 8-bit duty is 256 minus high, over 256
// - enable cleared holds pwm output low
// - reload bank select steers compare byte access
// - 9-11 bit: low N counter bits match sets
// - bit N overflow: low, flag, reload compare
// - 9/10/11 overflow every 512/1024/2048 ticks
// - 16-bit: full match high, overflow low
// - 16-bit match sets event flag when enabled
// - counter wrap sets overflow flag bit 7
// - control bit 6 runs or stops counter
// - bits 2:0 event flags, 5:3 read zero
// - three-bit field selects counter timebase
// - cycle overflow flag with enable raises interrupt
package counter_array_pkg;
  localparam logic [7:0] CTRL_ADDR     = 8'hD8;
  localparam logic [7:0] MODE_ADDR     = 8'hED;
  localparam logic [7:0] PWM_CFG_ADDR  = 8'hA1;
  localparam logic [7:0] MOD_MODE_BASE = 8'hDA;
  localparam logic [7:0] CMP_BASE      = 8'hE0;
  localparam int CTRL_CF_BIT  = 7;
  localparam int CTRL_CR_BIT  = 6;
  localparam int MM_WIDE_BIT  = 7;
  localparam int MM_ECOM_BIT  = 6;
  localparam int MM_MAT_BIT   = 3;
  localparam int MM_TOG_BIT   = 2;
  localparam int MM_PWM_BIT   = 1;
  localparam int MM_ECCF_BIT  = 0;
  localparam int MD_CIDL_BIT  = 7;
  localparam int MD_ECF_BIT   = 0;
  localparam int MD_CPS_LSB   = 1;
  localparam int PC_RELOAD_BANK_SELECT_BIT = 7;
  localparam int PC_CYCLE_OVERFLOW_IRQ_ENABLE_BIT  = 6;
  localparam int PC_CYCLE_OVERFLOW_FLAG_BIT  = 5;
  localparam logic [7:0]  REG_RESET  = 8'h00;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [3:0]  DIV12_LAST = 4'hB;
  localparam logic [1:0]  DIV4_LAST  = 2'h3;
  localparam logic [2:0]  EXT_DIV_LAST = 3'h7;
  typedef enum logic [2:0] {
    TB_DIV12  = 3'b000,
    TB_DIV4   = 3'b001,
    TB_TIMER0 = 3'b010,
    TB_ECI    = 3'b011,
    TB_SYSCLK = 3'b100,
    TB_EXT8   = 3'b101
  } timebase_t;
endpackage : counter_array_pkg

// >>> logic/counter_array_pwm.sv
`timescale 1ns/1ps
module counter_array_pwm #(
  parameter int NUM_MODULES = 3
) (
  input  wire logic                   ref_clk_in,
  input  wire logic                   reset_in,
  input  wire logic [7:0]             sfr_addr_in,
  input  wire logic [7:0]             sfr_wdata_in,
  input  wire logic                   sfr_wr_in,
  input  wire logic                   sfr_rd_in,
  input  wire logic                   cpu_idle_in,
  input  wire logic                   timer0_ovf_in,
  input  wire logic                   eci_in,
  input  wire logic                   ext_clk_in,
  output logic [7:0]                  sfr_rdata_out,
  output logic                        counter_irq_out,
  output logic [NUM_MODULES-1:0]      module_output_pin_out
);

  function automatic logic [7:0] mode_addr(input int idx);
    mode_addr = counter_array_pkg::MOD_MODE_BASE + 8'(idx);
  endfunction : mode_addr

  function automatic logic [7:0] cpl_addr(input int idx);
    cpl_addr = counter_array_pkg::CMP_BASE + 8'(2 * idx);
  endfunction : cpl_addr

  function automatic logic [7:0] cph_addr(input int idx);
    cph_addr = counter_array_pkg::CMP_BASE + 8'(2 * idx + 1);
  endfunction : cph_addr

  logic [15:0]            cnt_reg,      cnt_next;
  logic                   cf_reg,       cf_next;
  logic                   cr_reg,       cr_next;
  logic [NUM_MODULES-1:0] ccf_reg,      ccf_next;
  logic                   cidl_reg,     cidl_next;
  logic [2:0]             cps_reg,      cps_next;
  logic                   ecf_reg,      ecf_next;
  logic                   reload_bank_select_reg,    reload_bank_select_next;
  logic                   cycle_overflow_irq_enable_reg,     cycle_overflow_irq_enable_next;
  logic                   cycle_overflow_flag_reg,     cycle_overflow_flag_next;
  logic [1:0]             cycle_length_select_reg,    cycle_length_select_next;
  logic [3:0]             div_reg,      div_next;
  logic [2:0]             ext_div_reg,  ext_div_next;
  logic [2:0]             eci_sync_reg, eci_sync_next;
  logic [2:0]             ext_sync_reg, ext_sync_next;
  logic [7:0]             rdata_reg,    rdata_next;
  logic                   irq_reg,      irq_next;
  logic                   tick;
  logic                   tick_run;
  logic [15:0]            cyc_mask;
  logic [NUM_MODULES-1:0] ccf_set;
  logic [7:0]             mm_vec  [NUM_MODULES];
  logic [15:0]            cmp_vec [NUM_MODULES];
  logic [15:0]            rld_vec [NUM_MODULES];
  logic                   wr_ctrl;
  logic                   wr_mode;
  logic                   wr_pc;

  assign wr_ctrl = sfr_wr_in && (sfr_addr_in == counter_array_pkg::CTRL_ADDR);
  assign wr_mode = sfr_wr_in && (sfr_addr_in == counter_array_pkg::MODE_ADDR);
  assign wr_pc   = sfr_wr_in && (sfr_addr_in == counter_array_pkg::PWM_CFG_ADDR);

  // timebase and counter
  always_comb
  begin
    // the first sync stage feeds only the second; edges seen on stages 2 and 3
    eci_sync_next = {eci_sync_reg[1:0], eci_in};
    ext_sync_next = {ext_sync_reg[1:0], ext_clk_in};
    div_next = (div_reg == counter_array_pkg::DIV12_LAST) ? 4'h0 : div_reg + 4'h1;
    ext_div_next = ext_div_reg;
    if (ext_sync_reg[1] && !ext_sync_reg[2])
    begin
      ext_div_next = ext_div_reg + 3'h1;
    end
    case (counter_array_pkg::timebase_t'(cps_reg))
      counter_array_pkg::TB_DIV12:  tick = (div_reg == counter_array_pkg::DIV12_LAST);
      counter_array_pkg::TB_DIV4:   tick = (div_reg[1:0] == counter_array_pkg::DIV4_LAST);
      counter_array_pkg::TB_TIMER0: tick = timer0_ovf_in;
      counter_array_pkg::TB_ECI:    tick = eci_sync_reg[2] && !eci_sync_reg[1];
      counter_array_pkg::TB_SYSCLK: tick = 1'b1;
      counter_array_pkg::TB_EXT8:   tick = ext_sync_reg[1] && !ext_sync_reg[2]
                                           && (ext_div_reg == counter_array_pkg::EXT_DIV_LAST);
      default:                      tick = 1'b0;
    endcase
    // run control gates counting; idle suspends when asked
    tick_run = tick && cr_reg && !(cidl_reg && cpu_idle_in);
    cnt_next = tick_run ? cnt_reg + 16'h0001 : cnt_reg;
    // one cycle length for every 8-11 bit module
    case (cycle_length_select_reg)
      2'b00:   cyc_mask = 16'h00FF;
      2'b01:   cyc_mask = 16'h01FF;
      2'b10:   cyc_mask = 16'h03FF;
      default: cyc_mask = 16'h07FF;
    endcase
  end

  // control, mode and pwm config registers
  always_comb
  begin
    cf_next    = cf_reg;
    cr_next    = cr_reg;
    ccf_next   = ccf_reg;
    cidl_next  = cidl_reg;
    cps_next   = cps_reg;
    ecf_next   = ecf_reg;
    reload_bank_select_next = reload_bank_select_reg;
    cycle_overflow_irq_enable_next  = cycle_overflow_irq_enable_reg;
    cycle_overflow_flag_next  = cycle_overflow_flag_reg;
    cycle_length_select_next = cycle_length_select_reg;
    if (wr_ctrl)
    begin
      cf_next  = sfr_wdata_in[counter_array_pkg::CTRL_CF_BIT];
      cr_next  = sfr_wdata_in[counter_array_pkg::CTRL_CR_BIT];
      ccf_next = sfr_wdata_in[NUM_MODULES-1:0];
    end
    if (wr_mode)
    begin
      cidl_next = sfr_wdata_in[counter_array_pkg::MD_CIDL_BIT];
      cps_next  = sfr_wdata_in[counter_array_pkg::MD_CPS_LSB +: 3];
      ecf_next  = sfr_wdata_in[counter_array_pkg::MD_ECF_BIT];
    end
    if (wr_pc)
    begin
      reload_bank_select_next = sfr_wdata_in[counter_array_pkg::PC_RELOAD_BANK_SELECT_BIT];
      cycle_overflow_irq_enable_next  = sfr_wdata_in[counter_array_pkg::PC_CYCLE_OVERFLOW_IRQ_ENABLE_BIT];
      cycle_overflow_flag_next  = sfr_wdata_in[counter_array_pkg::PC_CYCLE_OVERFLOW_FLAG_BIT];
      cycle_length_select_next = sfr_wdata_in[1:0];
    end
    // full wrap sets flag; set beats a same-cycle clear
    if (tick_run && cnt_next == 16'h0000)
    begin
      cf_next = 1'b1;
    end
    // cycle overflow at bit 8/9/10/11 wrap
    if (tick_run && (cnt_next & cyc_mask) == 16'h0000)
    begin
      cycle_overflow_flag_next = 1'b1;
    end
    ccf_next = ccf_next | ccf_set;
    irq_next = (cf_reg && ecf_reg) || (cycle_overflow_flag_reg && cycle_overflow_irq_enable_reg);
    rdata_next = rdata_reg;
    if (sfr_rd_in)
    begin
      rdata_next = 8'h00;
      case (sfr_addr_in)
        counter_array_pkg::CTRL_ADDR:
          rdata_next = {cf_reg, cr_reg, 3'b000, 3'(ccf_reg)};
        counter_array_pkg::MODE_ADDR:
          rdata_next = {cidl_reg, 3'b000, cps_reg, ecf_reg};
        counter_array_pkg::PWM_CFG_ADDR:
          rdata_next = {reload_bank_select_reg, cycle_overflow_irq_enable_reg, cycle_overflow_flag_reg, 3'b000, cycle_length_select_reg};
        default:
          rdata_next = 8'h00;
      endcase
    end
    for (int i = 0; i < NUM_MODULES; i++)
    begin
      irq_next = irq_next || (ccf_reg[i] && mm_vec[i][counter_array_pkg::MM_ECCF_BIT]);
      if (sfr_rd_in && sfr_addr_in == mode_addr(i))
      begin
        rdata_next = mm_vec[i];
      end
      if (sfr_rd_in && sfr_addr_in == cpl_addr(i))
      begin
        rdata_next = reload_bank_select_reg ? rld_vec[i][7:0] : cmp_vec[i][7:0];
      end
      if (sfr_rd_in && sfr_addr_in == cph_addr(i))
      begin
        rdata_next = reload_bank_select_reg ? rld_vec[i][15:8] : cmp_vec[i][15:8];
      end
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (reset_in)
    begin
      cnt_reg      <= counter_array_pkg::WORD_RESET;
      cf_reg       <= 1'b0;
      cr_reg       <= 1'b0;
      ccf_reg      <= '0;
      cidl_reg     <= 1'b0;
      cps_reg      <= 3'b000;
      ecf_reg      <= 1'b0;
      reload_bank_select_reg    <= 1'b0;
      cycle_overflow_irq_enable_reg     <= 1'b0;
      cycle_overflow_flag_reg     <= 1'b0;
      cycle_length_select_reg    <= 2'b00;
      div_reg      <= 4'h0;
      ext_div_reg  <= 3'h0;
      eci_sync_reg <= 3'b111;
      ext_sync_reg <= 3'b000;
      rdata_reg    <= counter_array_pkg::REG_RESET;
      irq_reg      <= 1'b0;
    end
    else
    begin
      cnt_reg      <= cnt_next;
      cf_reg       <= cf_next;
      cr_reg       <= cr_next;
      ccf_reg      <= ccf_next;
      cidl_reg     <= cidl_next;
      cps_reg      <= cps_next;
      ecf_reg      <= ecf_next;
      reload_bank_select_reg    <= reload_bank_select_next;
      cycle_overflow_irq_enable_reg     <= cycle_overflow_irq_enable_next;
      cycle_overflow_flag_reg     <= cycle_overflow_flag_next;
      cycle_length_select_reg    <= cycle_length_select_next;
      div_reg      <= div_next;
      ext_div_reg  <= ext_div_next;
      eci_sync_reg <= eci_sync_next;
      ext_sync_reg <= ext_sync_next;
      rdata_reg    <= rdata_next;
      irq_reg      <= irq_next;
    end
  end

  assign sfr_rdata_out   = rdata_reg;
  assign counter_irq_out = irq_reg;

  // per-module compare and pwm output
  for (genvar g = 0; g < NUM_MODULES; g++)
  begin : gen_module
    logic [7:0]  mm_reg,  mm_next;
    logic [15:0] cmp_reg, cmp_next;
    logic [15:0] rld_reg, rld_next;
    logic        out_reg, out_next;
    logic        match_set;
    logic        wide;
    logic        wrap;
    logic [15:0] msk;
    logic [15:0] eff;

    always_comb
    begin
      mm_next   = mm_reg;
      cmp_next  = cmp_reg;
      rld_next  = rld_reg;
      out_next  = out_reg;
      match_set = 1'b0;
      wide      = mm_reg[counter_array_pkg::MM_WIDE_BIT];
      msk       = wide ? 16'hFFFF : cyc_mask;
      wrap      = (cnt_next & msk) == 16'h0000;
      eff       = cmp_reg;
      // enable cleared or not pwm keeps pin low
      if (!mm_reg[counter_array_pkg::MM_PWM_BIT] || mm_reg[counter_array_pkg::MM_TOG_BIT]
          || !mm_reg[counter_array_pkg::MM_ECOM_BIT])
      begin
        out_next = 1'b0;
      end
      else if (tick_run)
      begin
        if (wrap && !wide)
        begin
          // 8-bit wrap copies high byte into low
          if (cycle_length_select_reg == 2'b00)
          begin
            eff = {cmp_reg[15:8], cmp_reg[15:8]};
          end
          // reload value loaded at bit N overflow
          else
          begin
            eff = rld_reg;
          end
          cmp_next = eff;
        end
        // match sets pin; reloaded value used so zero means full duty
        // duty follows from set point against wrap
        if ((cnt_next & msk) == (eff & msk))
        begin
          out_next  = 1'b1;
          match_set = mm_reg[counter_array_pkg::MM_MAT_BIT];
        end
        else if (wrap)
        begin
          out_next = 1'b0;
        end
      end
      if (sfr_wr_in && sfr_addr_in == mode_addr(g))
      begin
        mm_next = sfr_wdata_in;
      end
      // low byte write, bank steered, enable cleared
      if (sfr_wr_in && sfr_addr_in == cpl_addr(g))
      begin
        if (reload_bank_select_reg)
        begin
          rld_next[7:0] = sfr_wdata_in;
        end
        else
        begin
          cmp_next[7:0] = sfr_wdata_in;
        end
        mm_next[counter_array_pkg::MM_ECOM_BIT] = 1'b0;
      end
      // high byte write, bank steered, enable set
      if (sfr_wr_in && sfr_addr_in == cph_addr(g))
      begin
        if (reload_bank_select_reg)
        begin
          rld_next[15:8] = sfr_wdata_in;
        end
        else
        begin
          cmp_next[15:8] = sfr_wdata_in;
        end
        mm_next[counter_array_pkg::MM_ECOM_BIT] = 1'b1;
      end
    end

    always_ff @(posedge ref_clk_in)
    begin
      if (reset_in)
      begin
        mm_reg  <= counter_array_pkg::REG_RESET;
        cmp_reg <= counter_array_pkg::WORD_RESET;
        rld_reg <= counter_array_pkg::WORD_RESET;
        out_reg <= 1'b0;
      end
      else
      begin
        mm_reg  <= mm_next;
        cmp_reg <= cmp_next;
        rld_reg <= rld_next;
        out_reg <= out_next;
      end
    end

    assign ccf_set[g]               = match_set;
    assign mm_vec[g]                = mm_reg;
    assign cmp_vec[g]               = cmp_reg;
    assign rld_vec[g]               = rld_reg;
    assign module_output_pin_out[g] = out_reg;
  end

endmodule : counter_array_pwm

// >>> tb/counter_array_pwm_properties.sv
`timescale 1ns/1ps
module counter_array_pwm_properties #(
  parameter int NUM_MODULES = 3
) (
  input wire logic                   ref_clk_in,
  input wire logic                   reset_in,
  input wire logic [7:0]             sfr_addr_in,
  input wire logic [7:0]             sfr_wdata_in,
  input wire logic                   sfr_wr_in,
  input wire logic                   sfr_rd_in,
  input wire logic                   cpu_idle_in,
  input wire logic                   timer0_ovf_in,
  input wire logic                   eci_in,
  input wire logic                   ext_clk_in,
  input wire logic [7:0]             sfr_rdata_out,
  input wire logic                   counter_irq_out,
  input wire logic [NUM_MODULES-1:0] module_output_pin_out
);
  logic cr_off_reg;
  logic cr_off_next;
  logic cr_off_d_reg;
  logic en_off_reg;
  logic en_off_next;
  logic en_off_d_reg;
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (reset_in);
  // shadows of run control and module 0 comparator enable
  always_comb
  begin
    cr_off_next = cr_off_reg;
    en_off_next = en_off_reg;
    if (sfr_wr_in && sfr_addr_in == counter_array_pkg::CTRL_ADDR)
      cr_off_next = !sfr_wdata_in[counter_array_pkg::CTRL_CR_BIT];
    if (sfr_wr_in && sfr_addr_in == counter_array_pkg::MOD_MODE_BASE)
      en_off_next = !sfr_wdata_in[counter_array_pkg::MM_ECOM_BIT];
    if (sfr_wr_in && sfr_addr_in == counter_array_pkg::CMP_BASE)
      en_off_next = 1'b1;
    if (sfr_wr_in && sfr_addr_in == counter_array_pkg::CMP_BASE + 8'h01)
      en_off_next = 1'b0;
  end
  always_ff @(posedge ref_clk_in)
  begin
    cr_off_reg   <= reset_in | cr_off_next;
    cr_off_d_reg <= reset_in | cr_off_reg;
    en_off_reg   <= reset_in | en_off_next;
    en_off_d_reg <= reset_in | en_off_reg;
  end
  reset_clear_a: assert property (disable iff (1'b0) $fell(reset_in) |->
    sfr_rdata_out == 8'h00 && module_output_pin_out == '0 && !counter_irq_out)
    else $error("outputs not cleared by reset");
  unmapped_zero_a: assert property (sfr_rd_in && sfr_addr_in == 8'h00 |=>
    sfr_rdata_out == 8'h00) else $error("unmapped read not zero");
  ctrl_reserved_a: assert property (sfr_rd_in && sfr_addr_in == 8'hD8 |=>
    sfr_rdata_out[5:3] == 3'b000) else $error("control reserved bits set");
  cfg_reserved_a: assert property (sfr_rd_in && sfr_addr_in == 8'hA1 |=>
    sfr_rdata_out[4:2] == 3'b000) else $error("pwm config reserved bits set");
  mode_reserved_a: assert property (sfr_rd_in && sfr_addr_in == 8'hED |=>
    sfr_rdata_out[6:4] == 3'b000) else $error("mode reserved bits set");
  rdata_hold_a: assert property (!sfr_rd_in |=> $stable(sfr_rdata_out))
    else $error("read data moved without a read");
  disabled_low_a: assert property (en_off_reg && en_off_d_reg |->
    !module_output_pin_out[0]) else $error("pin high with comparator off");
  stopped_hold_a: assert property (cr_off_reg && cr_off_d_reg && !sfr_wr_in
    && !$past(sfr_wr_in) |=> $stable(module_output_pin_out))
    else $error("pin moved with counter stopped");
  cover property ($rose(module_output_pin_out[0]));
  cover property ($rose(counter_irq_out));
  cover property (en_off_reg && en_off_d_reg && !cr_off_reg);
  cover property ($rose(module_output_pin_out[1]));
endmodule : counter_array_pwm_properties
bind counter_array_pwm counter_array_pwm_properties #(.NUM_MODULES(NUM_MODULES))
  counter_array_pwm_properties_inst (.ref_clk_in(ref_clk_in), .reset_in(reset_in),
  .sfr_addr_in(sfr_addr_in), .sfr_wdata_in(sfr_wdata_in), .sfr_wr_in(sfr_wr_in),
  .sfr_rd_in(sfr_rd_in), .cpu_idle_in(cpu_idle_in), .timer0_ovf_in(timer0_ovf_in),
  .eci_in(eci_in), .ext_clk_in(ext_clk_in), .sfr_rdata_out(sfr_rdata_out),
  .counter_irq_out(counter_irq_out), .module_output_pin_out(module_output_pin_out));

// >>> tb/testbench.sv
`timescale 1ns/1ps
`define CHECK(got, exp) begin tests_run++; if ((got) !== (exp)) begin $display("wrong value at %0t: got %h expected %h", $time, got, exp); num_errors++; end end
module testbench;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] exp;
  } row_t;
  logic       ref_clk_in;
  logic       reset_in;
  logic [7:0] sfr_addr_in;
  logic [7:0] sfr_wdata_in;
  logic       sfr_wr_in;
  logic       sfr_rd_in;
  logic [7:0] sfr_rdata_out;
  logic       counter_irq_out;
  logic [2:0] module_output_pin_out;
  logic       cpu_idle_in;
  logic       timer0_ovf_in = 1'b0;
  logic       eci_in = 1'b1;
  logic       ext_clk_in = 1'b0;
  int         num_errors = 0;
  int         tests_run = 0;
  int         n;
  int         m;
  int         phase = 0;
  row_t       rows [9] = '{'{8'hD8, 8'h87, 8'h87}, '{8'hD8, 8'h00, 8'h00},
    '{8'hED, 8'hFF, 8'h8F}, '{8'hED, 8'h00, 8'h00}, '{8'hA1, 8'hFF, 8'hE3},
    '{8'hA1, 8'h00, 8'h00}, '{8'hE0, 8'h5A, 8'h5A}, '{8'hE1, 8'hA5, 8'hA5},
    '{8'h00, 8'hFF, 8'h00}};
  logic [7:0] hbs [2] = '{8'hC0, 8'hFF};
  // mode byte per timebase and clocks per tick; 0 means no tick at all
  logic [7:0] tick_modes [8] = '{8'h08, 8'h00, 8'h02, 8'h04, 8'h06, 8'h0A, 8'h88, 8'h0C};
  int         tick_gaps [8] = '{1, 12, 4, 3, 4, 16, 1, 0};
  // timebase sources run free; only the selected one moves the counter
  counter_array_pwm #(.NUM_MODULES(3)) counter_array_pwm_inst (
    .ref_clk_in(ref_clk_in), .reset_in(reset_in), .sfr_addr_in(sfr_addr_in),
    .sfr_wdata_in(sfr_wdata_in), .sfr_wr_in(sfr_wr_in), .sfr_rd_in(sfr_rd_in),
    .cpu_idle_in(cpu_idle_in), .timer0_ovf_in(timer0_ovf_in), .eci_in(eci_in),
    .ext_clk_in(ext_clk_in),
    .sfr_rdata_out(sfr_rdata_out), .counter_irq_out(counter_irq_out),
    .module_output_pin_out(module_output_pin_out));
  initial
  begin
    ref_clk_in = 1'b0;
    forever #4 ref_clk_in = ~ref_clk_in;
  end
  // timer pulse every 3 clocks, falling edge every 4, ext rising every 2
  always @(posedge ref_clk_in)
  begin
    #1;
    phase = phase + 1;
    timer0_ovf_in = (phase % 3 == 0);
    eci_in = phase[1];
    ext_clk_in = ~ext_clk_in;
  end
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : wrap_up
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    #1;
    sfr_addr_in = a;
    sfr_wdata_in = d;
    sfr_wr_in = 1'b1;
    @(posedge ref_clk_in);
    #1;
    sfr_wr_in = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk_in);
    #1;
    sfr_addr_in = a;
    sfr_rd_in = 1'b1;
    @(posedge ref_clk_in);
    #1;
    sfr_rd_in = 1'b0;
    @(posedge ref_clk_in);
    #1;
    `CHECK(sfr_rdata_out, e)
  endtask : rd
  task automatic wait_pin(input logic lvl, input int lim);
    n = 0;
    while (module_output_pin_out[0] !== lvl && n < lim)
    begin
      @(posedge ref_clk_in);
      #1;
      n++;
    end
    if (n >= lim)
    begin
      num_errors++;
      wrap_up();
    end
  endtask : wait_pin
  // pin high time in clocks, timebase is the system clock
  task automatic high_time(input int lim, input int e);
    wait_pin(1'b0, lim);
    wait_pin(1'b1, lim);
    n = 0;
    while (module_output_pin_out[0] === 1'b1 && n < lim)
    begin
      @(posedge ref_clk_in);
      #1;
      n++;
    end
    `CHECK(n, e)
  endtask : high_time
  // clocks between count 1 on pin 0 and count 2 on pin 1
  task automatic tick_gap(input int e);
    n = 0;
    while (module_output_pin_out[0] !== 1'b1 && n < 200)
    begin
      @(posedge ref_clk_in);
      #1;
      n++;
    end
    m = 0;
    while (module_output_pin_out[1] !== 1'b1 && m < 200)
    begin
      @(posedge ref_clk_in);
      #1;
      m++;
    end
    if (n >= 200 || m >= 200)
    begin
      num_errors++;
      wrap_up();
    end
    `CHECK(m, e)
  endtask : tick_gap
  initial
  begin
    reset_in = 1'b1;
    sfr_addr_in = 8'h00;
    sfr_wdata_in = 8'h00;
    sfr_wr_in = 1'b0;
    sfr_rd_in = 1'b0;
    cpu_idle_in = 1'b0;
    repeat (2) @(posedge ref_clk_in);
    #1;
    reset_in = 1'b0;
    for (int i = 0; i < 9; i++)
      rd(rows[i].addr, 8'h00);
    $display("reset test done");
    for (int i = 0; i < 9; i++)
    begin
      wr(rows[i].addr, rows[i].wdata);
      rd(rows[i].addr, rows[i].exp);
    end
    $display("register table test done");
    wr(8'hA1, 8'h80);
    wr(8'hE1, 8'h3C);
    rd(8'hE1, 8'h3C);
    wr(8'hA1, 8'h00);
    rd(8'hE1, 8'hA5);
    $display("bank select test done");
    wr(8'hED, 8'h08);
    wr(8'hDA, 8'h4A);
    wr(8'hE0, 8'hC0);
    wr(8'hE1, 8'hC0);
    wr(8'hD8, 8'h40);
    // one full period lets the low byte reload first
    for (int i = 0; i < 2; i++)
    begin
      wr(8'hE1, hbs[i]);
      repeat (260) @(posedge ref_clk_in);
      #1;
      high_time(600, 256 - int'(hbs[i]));
    end
    rd(8'hD8, 8'h41);
    rd(8'hA1, 8'h20);
    wr(8'hE0, 8'h00);
    n = 0;
    repeat (300)
    begin
      @(posedge ref_clk_in);
      #1;
      if (module_output_pin_out[0] === 1'b1)
        n++;
    end
    `CHECK(n, 0)
    $display("eight bit test done");
    for (int nb = 9; nb <= 11; nb++)
    begin
      wr(8'hA1, 8'h80 | 8'(nb - 8));
      wr(8'hE0, 8'h00);
      wr(8'hE1, 8'h01);
      wr(8'hA1, 8'(nb - 8));
      repeat ((1 << nb) + 8) @(posedge ref_clk_in);
      #1;
      high_time(2 * (1 << nb) + 8, (1 << nb) - 256);
      rd(8'hE1, 8'h01);
    end
    $display("wide cycle test done");
    wr(8'hA1, 8'h00);
    wr(8'hED, 8'h09);
    wr(8'hDA, 8'hCA);
    wr(8'hE0, 8'hF0);
    wr(8'hE1, 8'hFF);
    wr(8'hD8, 8'h40);
    high_time(70000, 16);
    rd(8'hD8, 8'hC1);
    `CHECK(counter_irq_out, 1'b1)
    wr(8'hD8, 8'h00);
    repeat (3) @(posedge ref_clk_in);
    #1;
    `CHECK(counter_irq_out, 1'b0)
    repeat (20) @(posedge ref_clk_in);
    #1;
    $display("sixteen bit test done");
    for (int k = 0; k < 8; k++)
    begin
      reset_in = 1'b1;
      repeat (2) @(posedge ref_clk_in);
      #1;
      reset_in = 1'b0;
      cpu_idle_in = tick_modes[k][7];
      `CHECK({sfr_rdata_out, counter_irq_out, module_output_pin_out}, 12'h000)
      wr(8'hED, tick_modes[k]);
      wr(8'hDA, 8'h42);
      wr(8'hDB, 8'h42);
      wr(8'hE0, 8'h01);
      wr(8'hE1, 8'h01);
      wr(8'hE2, 8'h02);
      wr(8'hE3, 8'h02);
      wr(8'hD8, 8'h40);
      if (cpu_idle_in || tick_gaps[k] == 0)
      begin
        repeat (40) @(posedge ref_clk_in);
        #1;
        `CHECK(module_output_pin_out, 3'b000)
        cpu_idle_in = 1'b0;
      end
      if (tick_gaps[k] != 0)
        tick_gap(tick_gaps[k]);
    end
    $display("timebase test done");
    wrap_up();
  end
endmodule : testbench
